// *** data_prog_mem.sv ***
`timescale 1ns/100ps
`include "exec_defines.svh"

module data_prog_mem
  import exec_pkg::*;
(
  input wire logic clk_i,
  input wire dm_req_t dm_req_i,
  output logic [7:0] dm_rdata_o,
  input wire logic [`ADDR_W-1:0] pm_addr_i,
  input wire logic pm_re_i,
  output logic [7:0] pm_rdata_o
);
  logic [7:0] mem [0:1023];
  logic [7:0] last_reg;

  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = i[7:0] ^ 8'h5A;
    end
    last_reg = 8'h00;
    pm_rdata_o = 8'h00;
  end

  // Idle read bus shows the inverse of the last byte, never a stale copy
  assign dm_rdata_o = dm_req_i.re ? mem[dm_req_i.addr[9:0]] : ~last_reg;

  always @(posedge clk_i) begin
    if (dm_req_i.re) begin
      last_reg <= mem[dm_req_i.addr[9:0]];
    end
    if (dm_req_i.we) begin
      mem[dm_req_i.addr[9:0]] <= dm_req_i.wdata;
    end
    // Program byte is valid only in the cycle after the strobe
    pm_rdata_o <= pm_re_i ? (pm_addr_i[7:0] ^ 8'hC3) : ~pm_rdata_o;
  end
endmodule

// *** exec_defines.svh ***
`ifndef EXEC_DEFINES_SVH
`define EXEC_DEFINES_SVH

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define PC_W 16
`define ADDR_W 16
`define GPR_N 32
`define RIDX_W 5
`define PAIR_W 4
`define BR_OFS_W 7
`define DISP_W 6

// ----------------------------------------------------------------------
// Reset values and steps
// ----------------------------------------------------------------------
`define PC_RST 16'h0000
`define PC_STEP 16'h0001
`define PC_STEP_DIRECT 16'h0002
`define PTR_STEP 16'h0001
`define GPR_RST 8'h00

// ----------------------------------------------------------------------
// Register file positions
// ----------------------------------------------------------------------
`define R0_IDX 5'h00
`define PAIR_X 4'hD
`define PAIR_Y 4'hE
`define PAIR_Z 4'hF

`endif

// *** exec_pkg.sv ***
`include "exec_defines.svh"

package exec_pkg;

  typedef enum logic [3:0] {
    OP_NOP, OP_BR_TC, OP_BR_VS, OP_BR_VC, OP_BR_IE, OP_BR_ID,
    OP_MOV, OP_REGISTER_PAIR_COPY, OP_LDI, OP_LD_IND, OP_LD_DIRECT,
    OP_ST_IND, OP_ST_DIRECT, OP_LPM_R0, OP_LPM_RD, OP_LPM_INC
  } op_t;

  typedef enum logic [1:0] {PTR_X, PTR_Y, PTR_Z} ptr_t;

  typedef enum logic [1:0] {AM_PLAIN, AM_POST_INC, AM_PRE_DEC, AM_DISP} amode_t;

  typedef struct packed {
    op_t op;
    logic [`RIDX_W-1:0] rd;
    logic [`RIDX_W-1:0] rr;
    logic [7:0] imm;
    logic [`BR_OFS_W-1:0] bofs;
    ptr_t ptr;
    amode_t amode;
    logic [`DISP_W-1:0] disp;
    logic [`ADDR_W-1:0] abs_addr;
  } instr_t;

  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } dm_req_t;

endpackage

// *** flag_branch_exec.sv ***
`timescale 1ns/100ps
`include "exec_defines.svh"

module flag_branch_exec
  import exec_pkg::*;
(
  input wire logic SYS_CLK_I,
  input wire logic NRST_I,
  input wire instr_t INSTR_I,
  input wire logic INSTR_VALID_I,
  output logic INSTR_READY_O,
  input wire logic FLAG_T_I,
  input wire logic FLAG_V_I,
  input wire logic FLAG_GIE_I,
  output logic [`PC_W-1:0] PC_O,
  output dm_req_t DM_REQ_O,
  input wire logic [7:0] DM_RDATA_I,
  output logic [`ADDR_W-1:0] PM_ADDR_O,
  output logic PM_RE_O,
  input wire logic [7:0] PM_RDATA_I,
  input wire logic [`RIDX_W-1:0] RF_SEL_I,
  output logic [7:0] RF_DATA_O
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_BR_WAIT, ST_MEM, ST_PM_WAIT, ST_PM_CAP
  } state_t;

  // --------------------------------------------------------------------
  // Decoding helpers
  // --------------------------------------------------------------------
  function automatic logic [`PAIR_W-1:0] ptr_pair(input ptr_t p);
    case (p)
      PTR_X: ptr_pair = `PAIR_X;
      PTR_Y: ptr_pair = `PAIR_Y;
      default: ptr_pair = `PAIR_Z;
    endcase
  endfunction

  state_t state_reg, state_next;
  logic [`PC_W-1:0] pc_reg, pc_next;
  dm_req_t dm_reg, dm_next;
  logic [`ADDR_W-1:0] pm_addr_reg, pm_addr_next;
  logic pm_re_reg, pm_re_next;
  logic [`RIDX_W-1:0] dst_reg, dst_next;
  logic [7:0] gpr_reg [`GPR_N];
  logic [7:0] gpr_next [`GPR_N];

  logic wr_en;
  logic [`RIDX_W-1:0] wr_idx;
  logic [7:0] wr_data;
  logic pair_en;
  logic [`PAIR_W-1:0] pair_idx;
  logic [`ADDR_W-1:0] pair_val;

  instr_t ins;
  logic [`ADDR_W-1:0] ptr_cur, z_ptr, pu_addr, pu_ptr, br_target;
  logic [7:0] rr_data;
  logic pu_upd, br_take;

  assign ins = INSTR_I;
  assign INSTR_READY_O = (state_reg == ST_IDLE);
  assign PC_O = pc_reg;
  assign DM_REQ_O = dm_reg;
  assign PM_ADDR_O = pm_addr_reg;
  assign PM_RE_O = pm_re_reg;
  assign RF_DATA_O = gpr_reg[RF_SEL_I];
  assign rr_data = gpr_reg[ins.rr];
  assign ptr_cur = {gpr_reg[{ptr_pair(ins.ptr), 1'b1}],
                    gpr_reg[{ptr_pair(ins.ptr), 1'b0}]};
  assign z_ptr = {gpr_reg[{`PAIR_Z, 1'b1}], gpr_reg[{`PAIR_Z, 1'b0}]};
  assign br_target = pc_reg + `PC_STEP
    + {{(`PC_W-`BR_OFS_W){ins.bofs[`BR_OFS_W-1]}}, ins.bofs};

  ptr_addr_unit u_ptr (
    .ptr_i(ptr_cur),
    .amode_i(ins.amode),
    .disp_i(ins.disp),
    .disp_ok_i(ins.ptr != PTR_X),
    .addr_o(pu_addr),
    .ptr_new_o(pu_ptr),
    .upd_o(pu_upd)
  );

  // --------------------------------------------------------------------
  // Branch condition; flags are only read, never written
  // --------------------------------------------------------------------
  always_comb begin
    case (ins.op)
      OP_BR_TC: br_take = !FLAG_T_I;
      OP_BR_VS: br_take = FLAG_V_I;
      OP_BR_VC: br_take = !FLAG_V_I;
      OP_BR_IE: br_take = FLAG_GIE_I;
      OP_BR_ID: br_take = !FLAG_GIE_I;
      default: br_take = 1'b0;
    endcase
  end

  // --------------------------------------------------------------------
  // Sequencer
  // --------------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    pc_next = pc_reg;
    dm_next = dm_reg;
    pm_addr_next = pm_addr_reg;
    pm_re_next = 1'b0;
    dst_next = dst_reg;
    wr_en = 1'b0;
    wr_idx = dst_reg;
    wr_data = DM_RDATA_I;
    pair_en = 1'b0;
    pair_idx = ptr_pair(ins.ptr);
    pair_val = pu_ptr;
    case (state_reg)
      ST_IDLE: if (INSTR_VALID_I) begin
        pc_next = pc_reg + `PC_STEP;
        case (ins.op)
          OP_BR_TC, OP_BR_VS, OP_BR_VC, OP_BR_IE, OP_BR_ID: begin
            if (br_take) begin
              pc_next = br_target;
              state_next = ST_BR_WAIT;
            end
          end
          OP_MOV, OP_LDI: begin
            wr_en = 1'b1;
            wr_idx = ins.rd;
            wr_data = (ins.op == OP_MOV) ? rr_data : ins.imm;
          end
          OP_REGISTER_PAIR_COPY: begin
            pair_en = 1'b1;
            pair_idx = ins.rd[`RIDX_W-1:1];
            pair_val = {gpr_reg[{ins.rr[`RIDX_W-1:1], 1'b1}],
                        gpr_reg[{ins.rr[`RIDX_W-1:1], 1'b0}]};
          end
          OP_LD_IND, OP_ST_IND: begin
            // Pointer writes back now, access happens next cycle
            dm_next.addr = pu_addr;
            dm_next.re = (ins.op == OP_LD_IND);
            dm_next.we = (ins.op == OP_ST_IND);
            dm_next.wdata = rr_data;
            dst_next = ins.rd;
            pair_en = pu_upd;
            state_next = ST_MEM;
          end
          OP_LD_DIRECT, OP_ST_DIRECT: begin
            pc_next = pc_reg + `PC_STEP_DIRECT;
            dm_next.addr = ins.abs_addr;
            dm_next.re = (ins.op == OP_LD_DIRECT);
            dm_next.we = (ins.op == OP_ST_DIRECT);
            dm_next.wdata = rr_data;
            dst_next = ins.rd;
            state_next = ST_MEM;
          end
          OP_LPM_R0, OP_LPM_RD, OP_LPM_INC: begin
            pm_addr_next = z_ptr;
            pm_re_next = 1'b1;
            dst_next = (ins.op == OP_LPM_R0) ? `R0_IDX : ins.rd;
            pair_en = (ins.op == OP_LPM_INC);
            pair_idx = `PAIR_Z;
            pair_val = z_ptr + `PTR_STEP;
            state_next = ST_PM_WAIT;
          end
          default: ;
        endcase
      end
      ST_BR_WAIT: state_next = ST_IDLE;
      ST_MEM: begin
        wr_en = dm_reg.re;
        dm_next = '0;
        state_next = ST_IDLE;
      end
      // Program memory answers one cycle after the address
      ST_PM_WAIT: state_next = ST_PM_CAP;
      ST_PM_CAP: begin
        wr_en = 1'b1;
        wr_data = PM_RDATA_I;
        state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always_comb begin
    gpr_next = gpr_reg;
    if (wr_en) begin
      gpr_next[wr_idx] = wr_data;
    end
    if (pair_en) begin
      gpr_next[{pair_idx, 1'b1}] = pair_val[`ADDR_W-1:8];
      gpr_next[{pair_idx, 1'b0}] = pair_val[7:0];
    end
  end

  always_ff @(posedge SYS_CLK_I) begin
    if (!NRST_I) begin
      state_reg <= ST_IDLE;
      pc_reg <= `PC_RST;
      dm_reg <= '0;
      pm_addr_reg <= '0;
      pm_re_reg <= 1'b0;
      dst_reg <= `R0_IDX;
      for (int i = 0; i < `GPR_N; i++) begin
        gpr_reg[i] <= `GPR_RST;
      end
    end else begin
      state_reg <= state_next;
      pc_reg <= pc_next;
      dm_reg <= dm_next;
      pm_addr_reg <= pm_addr_next;
      pm_re_reg <= pm_re_next;
      dst_reg <= dst_next;
      gpr_reg <= gpr_next;
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!NRST_I);

  logic acc;
  assign acc = INSTR_VALID_I && INSTR_READY_O;

  a_branch_transfer_flag_clear_taken: assert property (
    acc && ins.op == OP_BR_TC && !FLAG_T_I |=> PC_O == $past(br_target)
    && !INSTR_READY_O ##1 INSTR_READY_O)
    else $error("taken branch target or timing wrong");
  a_branch_overflow_set_fall: assert property (
    acc && ins.op == OP_BR_VS && !FLAG_V_I
    |=> PC_O == $past(pc_reg) + `PC_STEP && INSTR_READY_O)
    else $error("untaken branch not one cycle");
  a_branch_overflow_clear_target: assert property (
    acc && ins.op == OP_BR_VC && !FLAG_V_I |=> PC_O == $past(br_target))
    else $error("overflow clear branch target wrong");
  a_branch_interrupts_enabled_stall: assert property (
    acc && ins.op == OP_BR_IE && FLAG_GIE_I |=> !INSTR_READY_O)
    else $error("taken branch did not stall");
  a_branch_interrupts_disabled_fall: assert property (
    acc && ins.op == OP_BR_ID && FLAG_GIE_I |=> INSTR_READY_O)
    else $error("untaken branch stalled");
  a_ld_postinc: assert property (
    acc && ins.op == OP_LD_IND && ins.amode == AM_POST_INC
    |=> DM_REQ_O.re && DM_REQ_O.addr == $past(ptr_cur) ##1 INSTR_READY_O)
    else $error("post-increment load address wrong");
  a_ld_predec: assert property (
    acc && ins.op == OP_LD_IND && ins.amode == AM_PRE_DEC
    |=> DM_REQ_O.addr == $past(ptr_cur) - `PTR_STEP)
    else $error("pre-decrement load address wrong");
  a_st_disp: assert property (
    acc && ins.op == OP_ST_IND && ins.amode == AM_DISP && ins.ptr == PTR_Z
    |=> DM_REQ_O.we && DM_REQ_O.wdata == $past(rr_data)
    && DM_REQ_O.addr == $past(ptr_cur) + $past(ins.disp))
    else $error("displacement store wrong");
  a_st_direct: assert property (
    acc && ins.op == OP_ST_DIRECT |=> DM_REQ_O.we
    && DM_REQ_O.addr == $past(ins.abs_addr) ##1 !DM_REQ_O.we)
    else $error("direct store wrong");
  a_move_single: assert property (
    acc && ins.op inside {OP_MOV, OP_REGISTER_PAIR_COPY, OP_LDI} |=> INSTR_READY_O)
    else $error("move took more than one cycle");
  a_pm_three: assert property (
    acc && ins.op inside {OP_LPM_R0, OP_LPM_RD, OP_LPM_INC}
    |=> PM_RE_O && PM_ADDR_O == $past(z_ptr)
    ##1 !INSTR_READY_O ##1 INSTR_READY_O)
    else $error("program read not three cycles");
  a_pm_inc: assert property (
    acc && ins.op == OP_LPM_INC && ins.rd[`RIDX_W-1:1] != `PAIR_Z
    |=> z_ptr == $past(z_ptr) + `PTR_STEP)
    else $error("third pair not incremented");

  c_br_taken: cover property (acc && ins.op == OP_BR_TC && !FLAG_T_I);
  c_ld_ind: cover property (acc && ins.op == OP_LD_IND);
  c_st_ind: cover property (acc && ins.op == OP_ST_IND);
  c_pm_inc: cover property (acc && ins.op == OP_LPM_INC);

endmodule

// *** ptr_addr_unit.sv ***
`timescale 1ns/100ps
`include "exec_defines.svh"

module ptr_addr_unit
  import exec_pkg::*;
(
  input wire logic [`ADDR_W-1:0] ptr_i,
  input wire amode_t amode_i,
  input wire logic [`DISP_W-1:0] disp_i,
  input wire logic disp_ok_i,
  output logic [`ADDR_W-1:0] addr_o,
  output logic [`ADDR_W-1:0] ptr_new_o,
  output logic upd_o
);

  always_comb begin
    addr_o = ptr_i;
    ptr_new_o = ptr_i;
    upd_o = 1'b0;
    case (amode_i)
      AM_POST_INC: begin
        ptr_new_o = ptr_i + `PTR_STEP;
        upd_o = 1'b1;
      end
      AM_PRE_DEC: begin
        ptr_new_o = ptr_i - `PTR_STEP;
        addr_o = ptr_new_o;
        upd_o = 1'b1;
      end
      AM_DISP: begin
        // Pointer untouched; first pair has no displacement form
        if (disp_ok_i) begin
          addr_o = ptr_i + {{(`ADDR_W-`DISP_W){1'b0}}, disp_i};
        end
      end
      default: ;
    endcase
  end

endmodule

// *** tb_top.sv ***
`timescale 1ns/100ps
`include "exec_defines.svh"

module tb_top;
  import exec_pkg::*;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  instr_t instr = '0;
  logic valid = 1'h0;
  logic ft = 1'h0, fv = 1'h0, fi = 1'h0;
  logic [4:0] sel = 5'h00;
  logic ready, pm_re;
  logic [15:0] pc, pm_addr, pa1;
  logic [7:0] dm_rdata, pm_rdata, rf_data;
  dm_req_t dm_req, dm1;
  logic pr1;
  int cyc;
  int n_errors = 0;
  int checks = 0;

  always #20 clk = ~clk;

  flag_branch_exec dut (
    .SYS_CLK_I(clk), .NRST_I(nrst), .INSTR_I(instr),
    .INSTR_VALID_I(valid), .INSTR_READY_O(ready), .FLAG_T_I(ft),
    .FLAG_V_I(fv), .FLAG_GIE_I(fi), .PC_O(pc), .DM_REQ_O(dm_req),
    .DM_RDATA_I(dm_rdata), .PM_ADDR_O(pm_addr), .PM_RE_O(pm_re),
    .PM_RDATA_I(pm_rdata), .RF_SEL_I(sel), .RF_DATA_O(rf_data)
  );

  data_prog_mem mem (
    .clk_i(clk), .dm_req_i(dm_req), .dm_rdata_o(dm_rdata),
    .pm_addr_i(pm_addr), .pm_re_i(pm_re), .pm_rdata_o(pm_rdata)
  );

  // --------------------------------------------------------------
  // Stimulus helpers
  // --------------------------------------------------------------
  task automatic final_report;
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string s, input logic [15:0] e,
                     input logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask

  // Captures the cycle-1 outputs, then counts cycles until ready
  task automatic issue(input instr_t i);
    @(posedge clk);
    instr <= i;
    valid <= 1'h1;
    @(posedge clk);
    valid <= 1'h0;
    #1;
    dm1 = dm_req;
    pr1 = pm_re;
    pa1 = pm_addr;
    cyc = 1;
    while (ready !== 1'h1 && cyc < 9) begin
      @(posedge clk);
      #1;
      cyc++;
    end
  endtask

  function automatic logic [4:0] pr(input ptr_t p);
    return 5'h1A + {2'h0, p, 1'h0};
  endfunction

  task automatic getr(input logic [4:0] x, output logic [7:0] v);
    @(posedge clk);
    sel <= x;
    #1;
    v = rf_data;
  endtask

  task automatic getp(input ptr_t p, output logic [15:0] v);
    getr(pr(p), v[7:0]);
    getr(pr(p) + 5'h01, v[15:8]);
  endtask

  task automatic immediate_load(input logic [4:0] rd, input logic [7:0] k);
    instr_t i;
    i = '0;
    i.op = OP_LDI;
    i.rd = rd;
    i.imm = k;
    issue(i);
  endtask

  task automatic setp(input ptr_t p, input logic [15:0] v);
    immediate_load(pr(p), v[7:0]);
    immediate_load(pr(p) + 5'h01, v[15:8]);
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_branch;
    instr_t i;
    logic tk;
    logic [15:0] e;
    op_t ops [5] = '{OP_BR_TC, OP_BR_VS, OP_BR_VC, OP_BR_IE, OP_BR_ID};
    for (int f = 0; f < 2; f++) begin
      for (int k = 0; k < 5; k++) begin
        i = '0;
        i.op = ops[k];
        i.bofs = f[0] ? 7'h7D : 7'h3F;
        tk = (k == 0 || k == 2 || k == 4) ^ f[0];
        e = pc + 16'h1 + (tk ? {{9{i.bofs[6]}}, i.bofs} : 16'h0);
        @(posedge clk);
        ft <= f[0];
        fv <= f[0];
        fi <= f[0];
        issue(i);
        chk("branch pc", e, pc);
        chk("branch cycles", tk ? 16'h2 : 16'h1, cyc[15:0]);
      end
    end
  endtask

  task automatic t_moves;
    instr_t i;
    logic [7:0] v;
    immediate_load(5'h10, 8'hA5);
    chk("ldi cycles", 16'h1, cyc[15:0]);
    immediate_load(5'h11, 8'h3C);
    i = '0;
    i.op = OP_MOV;
    i.rd = 5'h01;
    i.rr = 5'h10;
    issue(i);
    chk("mov cycles", 16'h1, cyc[15:0]);
    i.op = OP_REGISTER_PAIR_COPY;
    i.rd = 5'h02;
    issue(i);
    chk("register_pair_copy cycles", 16'h1, cyc[15:0]);
    getr(5'h01, v);
    chk("mov r1", 16'hA5, v);
    getr(5'h02, v);
    chk("register_pair_copy low", 16'hA5, v);
    getr(5'h03, v);
    chk("register_pair_copy high", 16'h3C, v);
  endtask

  task automatic direct(input logic st, input logic [15:0] a,
                        input logic [7:0] k);
    instr_t i;
    logic [15:0] p0;
    logic [7:0] v;
    if (st) begin
      immediate_load(5'h15, k);
    end
    p0 = pc;
    i = '0;
    i.op = st ? OP_ST_DIRECT : OP_LD_DIRECT;
    i.rd = 5'h14;
    i.rr = 5'h15;
    i.abs_addr = a;
    issue(i);
    chk("direct cycles", 16'h2, cyc[15:0]);
    chk("direct addr", a, dm1.addr);
    chk("direct strobe", 16'h1, st ? dm1.we : dm1.re);
    chk("direct strobe end", 16'h0, {dm_req.we, dm_req.re});
    chk("direct pc", p0 + `PC_STEP_DIRECT, pc);
    if (st) begin
      chk("direct wdata", k, dm1.wdata);
    end else begin
      getr(5'h14, v);
      chk("direct data", k, v);
    end
  endtask

  // Indirect transfer; stores are read back with a direct load
  task automatic mx(input logic st, input ptr_t p, input amode_t am,
      input logic [5:0] d, input logic [15:0] p0, input logic [15:0] ea,
      input logic [15:0] pe);
    instr_t i;
    logic [7:0] v;
    logic [15:0] pv;
    setp(p, p0);
    immediate_load(5'h15, ea[7:0] ^ 8'hA5);
    i = '0;
    i.op = st ? OP_ST_IND : OP_LD_IND;
    i.rd = 5'h14;
    i.rr = 5'h15;
    i.ptr = p;
    i.amode = am;
    i.disp = d;
    issue(i);
    chk("xfer cycles", 16'h2, cyc[15:0]);
    chk("xfer addr", ea, dm1.addr);
    chk("xfer strobe", 16'h1, st ? dm1.we : dm1.re);
    chk("xfer other strobe", 16'h0, st ? dm1.re : dm1.we);
    chk("xfer strobe end", 16'h0, {dm_req.we, dm_req.re});
    getp(p, pv);
    chk("pointer after", pe, pv);
    if (st) begin
      chk("store wdata", ea[7:0] ^ 8'hA5, dm1.wdata);
      direct(1'h0, ea, ea[7:0] ^ 8'hA5);
    end else begin
      getr(5'h14, v);
      chk("load data", ea[7:0] ^ 8'h5A, v);
    end
  endtask

  task automatic prog(input op_t o, input logic [15:0] z,
                      input logic [15:0] ze);
    instr_t i;
    logic [7:0] v;
    logic [15:0] pv;
    setp(PTR_Z, z);
    i = '0;
    i.op = o;
    i.rd = 5'h16;
    issue(i);
    chk("prog cycles", 16'h3, cyc[15:0]);
    chk("prog strobe end", 16'h0, pm_re);
    chk("prog strobe", 16'h1, pr1);
    chk("prog addr", z, pa1);
    getr(o == OP_LPM_R0 ? `R0_IDX : 5'h16, v);
    chk("prog data", z[7:0] ^ 8'hC3, v);
    getp(PTR_Z, pv);
    chk("prog pointer", ze, pv);
  endtask

  // Mid-run reset, then a plain instruction right after release
  task automatic t_reset;
    instr_t i;
    logic [7:0] v;
    @(posedge clk);
    nrst <= 1'h0;
    repeat (2) @(posedge clk);
    nrst <= 1'h1;
    #1;
    chk("rerun pc", 16'h0000, pc);
    chk("rerun ready", 16'h1, ready);
    chk("rerun pm addr", 16'h0000, pm_addr);
    chk("rerun strobes", 16'h0, {pm_re, dm_req.we, dm_req.re});
    getr(5'h14, v);
    chk("rerun register", 16'h00, v);
    i = '0;
    issue(i);
    chk("nop cycles", 16'h1, cyc[15:0]);
    chk("nop pc", `PC_STEP, pc);
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    #400000;
    n_errors++;
    final_report();
  end

  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'h1;
    #1;
    chk("reset pc", 16'h0000, pc);
    chk("reset ready", 16'h1, ready);
    t_branch();
    t_moves();
    mx(1'h0, PTR_X, AM_POST_INC, 6'h0, 16'h100, 16'h100, 16'h101);
    mx(1'h0, PTR_Z, AM_POST_INC, 6'h0, 16'h3FF, 16'h3FF, 16'h400);
    mx(1'h0, PTR_Y, AM_PRE_DEC, 6'h0, 16'h200, 16'h1FF, 16'h1FF);
    mx(1'h0, PTR_X, AM_PRE_DEC, 6'h0, 16'h100, 16'h0FF, 16'h0FF);
    mx(1'h0, PTR_Y, AM_DISP, 6'h3F, 16'h210, 16'h24F, 16'h210);
    mx(1'h0, PTR_Z, AM_DISP, 6'h01, 16'h330, 16'h331, 16'h330);
    mx(1'h0, PTR_X, AM_DISP, 6'h07, 16'h160, 16'h160, 16'h160);
    mx(1'h0, PTR_Y, AM_PLAIN, 6'h0, 16'h150, 16'h150, 16'h150);
    mx(1'h1, PTR_X, AM_POST_INC, 6'h0, 16'h180, 16'h180, 16'h181);
    mx(1'h1, PTR_Y, AM_PRE_DEC, 6'h0, 16'h282, 16'h281, 16'h281);
    mx(1'h1, PTR_Z, AM_PRE_DEC, 6'h0, 16'h300, 16'h2FF, 16'h2FF);
    mx(1'h1, PTR_Y, AM_DISP, 6'h3F, 16'h290, 16'h2CF, 16'h290);
    mx(1'h1, PTR_Z, AM_DISP, 6'h05, 16'h340, 16'h345, 16'h340);
    direct(1'h0, 16'h0123, 8'h79);
    direct(1'h1, 16'h03A0, 8'h6E);
    direct(1'h0, 16'h03A0, 8'h6E);
    prog(OP_LPM_R0, 16'h412, 16'h412);
    prog(OP_LPM_RD, 16'h4FF, 16'h4FF);
    prog(OP_LPM_INC, 16'h4FF, 16'h500);
    t_reset();
    final_report();
  end
endmodule
